// File: design/prf_crc8.sv
// Purpose: serial-equivalent 8-bit CRC over a right-aligned message
// Assumes: message length never exceeds MSG_W
// Notes:   unrolled shift register, one bit per loop step
module prf_crc8 (
	input  logic [3:0]            sid,
	input  logic [prf_pkg::MSG_W-1:0] msg,
	input  logic [4:0]            msg_n,
	output logic [7:0]            crc
);
	import prf_pkg::*;

	// seed, message msb first, then eight zeros
	always_comb begin
		logic [7:0] c;
		logic       fb;
		c = {CRC_SEED_HI, sid};
		fb = 1'b0;
		for (int k = MSG_W - 1; k >= 0; k--) begin
			if (k < int'(msg_n)) begin
				fb = c[7];
				c = {c[6:0], msg[k]} ^ (fb ? CRC_POLY : 8'h00);
			end
		end
		for (int z = 0; z < 8; z++) begin
			fb = c[7];
			c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		crc = c;
	end
endmodule

// File: design/prf_framer.sv
// Purpose: periodic response framer with diagnostic command assembly
// Assumes: decoded commands arrive as one-cycle strobes, two cycles apart
// Notes:   registers over AHB-Lite, zero wait states, always OKAY
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
module prf_framer (
	input  logic                  hclk,
	input  logic                  hresetn,
	input  logic                  hsel,
	input  logic [7:0]            haddr,
	input  logic [1:0]            htrans,
	input  logic                  hwrite,
	input  logic [2:0]            hsize,
	input  logic [31:0]           hwdata,
	input  logic                  hready,
	output logic [31:0]           hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	input  logic                  cmd_valid,
	input  prf_pkg::prf_cmd_t     cmd,
	input  prf_pkg::prf_cond_t    device_condition_flags,
	input  logic                  supply_timer_running,
	input  prf_pkg::prf_samples_t samples,
	input  logic                  diag_cmd_ok,
	output logic                  resp_valid,
	output prf_pkg::prf_resp_t    resp,
	output logic [31:0]           diag_word,
	output logic                  diag_start,
	output logic                  diag_read_slot,
	output logic                  diag_abort
);
	import prf_pkg::*;

	typedef enum logic [2:0] {
		S_OFF = 3'b001,
		S_RUN = 3'b010,
		S_BDM = 3'b100
	} prf_state_t;

	prf_state_t       state_r;
	logic [31:0]      ctrl_r;
	logic [NSRC-1:0][31:0] src_r;
	logic [7:0]       addr_r;
	logic             wr_r;
	logic [31:0]      hrdata_r;
	logic [5:0]       asm_cnt_r;
	logic [31:0]      asm_r;
	logic             chk_r;
	logic [3:0]       reads_r;
	logic [NSRC-1:0][1:0] kac_r;
	logic             resp_valid_r;
	prf_resp_t        resp_r;
	logic             start_r;
	logic             slot_r;
	logic             abort_r;
	logic [3:0]       code;
	logic [1:0]       sel;
	logic [31:0]      src_cur;
	logic [2:0]       lay;
	logic [3:0]       sid;
	logic [1:0]       kac_cur;
	logic             active;
	logic             frag4;
	logic             is_bcast;
	logic             is_frag;
	logic             is_clr;
	logic             suppress;
	logic             send;
	logic             use_err;
	logic [DATA_W-1:0] data_f;
	logic [MSG_W-1:0] msg_w;
	logic [4:0]       msg_n;
	logic [7:0]       crc;
	logic [3:0]       reads_need;
	logic [7:0]       src_lo;

	assign sel      = ctrl_r[CTL_SEL +: 2];
	assign src_cur  = src_r[sel];
	assign lay      = src_cur[SRC_LAY +: 3];
	assign sid      = src_cur[SRC_ID +: 4];
	assign kac_cur  = kac_r[sel];
	assign frag4    = ctrl_r[CTL_FRAG4];
	assign active   = (state_r != S_OFF);
	// broadcast read: any single bit, no check of its value
	assign is_bcast = (cmd.len == LEN_BCAST);
	assign is_frag  = ctrl_r[CTL_DIAG] &&
		(cmd.len == (frag4 ? LEN_FRAG4 : LEN_FRAG2));
	assign is_clr   = is_bcast ||
		((cmd.len != LEN_FRAG2) && (cmd.len != LEN_FRAG4));
	assign reads_need = frag4 ? READS_FRAG4 : READS_FRAG2;
	// offset of a read into the per-source window
	assign src_lo   = haddr - OFF_SRC0;
	// supply fault holds replies back while its timer runs
	assign suppress = (code == STS_SUPPLY) && supply_timer_running;
	assign send     = cmd_valid && active && (is_bcast || is_frag) &&
		!suppress;

	prf_status_pick u_pick (
		.cond (device_condition_flags),
		.code (code)
	);

	// error code replaces data by class of status and layout
	always_comb begin
		use_err = 1'b0;
		if (code == STS_SUPPLY)
			use_err = !ctrl_r[CTL_SUPDIS];
		else if (code[3])
			use_err = 1'b1;
		else if (code != STS_NORMAL)
			use_err = !lay[LAY_STS];
		data_f = use_err ? DATA_ERR_CODE :
			samples[src_cur[SRC_KIND +: 2]];
	end

	// message assembly in transmit order, right aligned
	always_comb begin
		msg_w = '0;
		msg_n = '0;
		if (lay[LAY_ID]) begin
			msg_w = {msg_w[MSG_W-5:0], sid};
			msg_n = msg_n + 5'd4;
		end
		if (lay[LAY_KAC]) begin
			msg_w = {msg_w[MSG_W-3:0], kac_cur};
			msg_n = msg_n + 5'd2;
		end
		if (lay[LAY_STS]) begin
			msg_w = {msg_w[MSG_W-5:0], code};
			msg_n = msg_n + 5'd4;
		end
		msg_w = {msg_w[MSG_W-DATA_W-1:0], data_f};
		msg_n = msg_n + 5'(DATA_W);
	end

	prf_crc8 u_crc (
		.sid   (sid),
		.msg   (msg_w),
		.msg_n (msg_n),
		.crc   (crc)
	);

	// response frame register and strobe
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_valid_r <= 1'b0;
			resp_r       <= '0;
		end else begin
			resp_valid_r <= send;
			if (send) begin
				resp_r.len  <= msg_n + 5'd8;
				resp_r.bits <= {msg_w, crc};
			end
		end
	end

	// per-source keep-alive counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			kac_r <= '0;
		end else if (send) begin
			kac_r[sel] <= kac_cur + 2'h1;
		end
	end

	// mode state: off until init, then collecting or serving reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= S_OFF;
			reads_r <= '0;
			start_r <= 1'b0;
			slot_r  <= 1'b0;
			abort_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			slot_r  <= 1'b0;
			abort_r <= 1'b0;
			unique case (state_r)
				S_OFF: begin
					if (ctrl_r[CTL_INIT])
						state_r <= S_RUN;
				end
				S_RUN: begin
					if (chk_r && diag_cmd_ok) begin
						start_r <= 1'b1;
						reads_r <= '0;
						state_r <= S_BDM;
					end
				end
				S_BDM: begin
					if (cmd_valid && is_bcast) begin
						slot_r  <= 1'b1;
						reads_r <= reads_r + 4'h1;
						if (reads_r + 4'h1 == reads_need)
							state_r <= S_RUN;
					end else if (cmd_valid) begin
						abort_r <= 1'b1;
						state_r <= S_RUN;
					end
				end
			endcase
		end
	end

	// diagnostic fragment assembly
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			asm_r     <= '0;
			asm_cnt_r <= '0;
			chk_r     <= 1'b0;
		end else begin
			chk_r <= 1'b0;
			if (cmd_valid && active && is_clr) begin
				asm_cnt_r <= '0;
			end else if (cmd_valid && active && is_frag) begin
				asm_r <= frag4 ? {asm_r[27:0], cmd.bits[3:0]} :
					{asm_r[29:0], cmd.bits[1:0]};
				if (asm_cnt_r + cmd.len == DIAG_BITS) begin
					asm_cnt_r <= '0;
					chk_r     <= 1'b1;
				end else begin
					asm_cnt_r <= asm_cnt_r + cmd.len;
				end
			end
		end
	end

	// ahb address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_r   <= '0;
			wr_r     <= 1'b0;
			hrdata_r <= '0;
		end else begin
			wr_r <= hsel && htrans[1] && hready && hwrite;
			if (hsel && htrans[1] && hready) begin
				addr_r <= haddr;
				if (!hwrite) begin
					if (haddr == OFF_CTRL)
						hrdata_r <= ctrl_r;
					else if (haddr == OFF_STAT)
						hrdata_r <= {11'h000, state_r, asm_cnt_r,
							kac_r, code};
					else if (haddr >= OFF_SRC0 && haddr < OFF_STAT &&
						src_lo[1:0] == 2'h0)
						hrdata_r <= src_r[src_lo[3:2]];
					else
						hrdata_r <= '0;
				end
			end
		end
	end

	// register writes in the data phase; init bit only sets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= '0;
			for (int i = 0; i < NSRC; i++)
				src_r[i] <= {22'h000000, 2'h0, 1'b0, LAY_RST, 4'(i)};
		end else if (wr_r) begin
			if (addr_r == OFF_CTRL)
				ctrl_r <= {26'h0000000, hwdata[5:1],
					hwdata[CTL_INIT] | ctrl_r[CTL_INIT]};
			for (int i = 0; i < NSRC; i++)
				if (addr_r == OFF_SRC0 + 8'(4 * i))
					src_r[i] <= {22'h000000, hwdata[9:8], 1'b0,
						hwdata[6:0]};
		end
	end

	assign hrdata         = hrdata_r;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign resp_valid     = resp_valid_r;
	assign resp           = resp_r;
	assign diag_word      = asm_r;
	assign diag_start     = start_r;
	assign diag_read_slot = slot_r;
	assign diag_abort     = abort_r;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_no_init_quiet: assert property (
		cmd_valid && state_r == S_OFF |=> !resp_valid)
		else $error("response sent before init complete");
	a_bcast_answer: assert property (
		cmd_valid && active && cmd.len == LEN_BCAST && !suppress
		|=> resp_valid)
		else $error("broadcast read not answered");
	a_nodiag_other: assert property (
		cmd_valid && !ctrl_r[CTL_DIAG] && cmd.len != LEN_BCAST
		|=> !resp_valid)
		else $error("answer to non broadcast with diagnostics off");
	a_frag_answer: assert property (
		cmd_valid && active && ctrl_r[CTL_DIAG] && !suppress &&
		cmd.len == (frag4 ? LEN_FRAG4 : LEN_FRAG2) |=> resp_valid)
		else $error("fragment not answered");
	a_clear_decode: assert property (
		cmd_valid && active && cmd.len != LEN_FRAG2 &&
		cmd.len != LEN_FRAG4 |=> asm_cnt_r == 6'h00 && !chk_r)
		else $error("assembly not cleared");
	a_diag_start: assert property (
		diag_start |-> $past(chk_r) && $past(diag_cmd_ok))
		else $error("diagnostic start without full valid word");
	a_kac_step: assert property (
		send ##1 $stable(sel) |-> kac_cur == $past(kac_cur) + 2'h1)
		else $error("keep-alive did not advance by one");
	a_supply_quiet: assert property (
		cmd_valid && code == STS_SUPPLY && supply_timer_running
		|=> !resp_valid)
		else $error("reply during supply timer");
	a_prio_reset: assert property (
		device_condition_flags.reset_occurred_flag |-> code == STS_RESET)
		else $error("reset condition not top priority");
	a_crc_len: assert property (
		resp_valid |-> resp.len > 5'(DATA_W + 8) - 5'd1)
		else $error("frame shorter than data plus crc");

	c_bcast: cover property (cmd_valid && is_bcast ##1 resp_valid);
	c_diag_start: cover property (diag_start);
	c_diag_done: cover property (
		state_r == S_BDM ##1 state_r == S_RUN && !diag_abort);
	c_err_data: cover property (send && use_err);
endmodule

// File: design/prf_pkg.sv
// Purpose: shared constants and carriers of the periodic response framer
// Assumes: one 25 MHz clock, AHB-Lite register access
// Notes:   register offsets and control/source field positions live here; status word layout is built in the framer
// Contract
// - periodic collection and diagnostics start only after init-complete is set
// - while enabled, decode broadcast reads and diagnostic command fragments
// - diagnostics off: respond only to one-bit broadcast read, nothing else
// - a broadcast read of value one or zero is equally valid
// - diagnostic fragments are 2 or 4 bits as the width select says
// - diagnostics on: respond exactly to broadcast reads and fragments
// - broadcast read or length other than 2 or 4 clears assembly
// - diagnostic response only after full 32 bits decode to valid command
// - assembled command uses the command-mode error check
// - broadcast reads get no error check at all
// - frame order is id, keep-alive, status, data, CRC; layout sets sizes
// - id field carries the per-source 4-bit identifier when enabled
// - keep-alive is a 2-bit per-source counter from zero, one step per message
// - sensor data is the sample chosen by the source's kind select
// - every response ends with an 8-bit CRC over its contents
// - CRC poly 0x2f MSB first, seed 0000 plus id, eight zeros appended
// - codes 0000-0101 priorities 16-11; no status field means error code data
// - codes 1000-1011 and 1101 always replace data by the error code
// - supply error 1100 silences replies until timer expiry, then error code; with CTL_SUPDIS set the framer sends the sample data instead
package prf_pkg;
	localparam int unsigned NSRC   = 4;
	localparam int unsigned DATA_W = 10;
	localparam int unsigned MSG_W  = 20;
	localparam int unsigned FRM_W  = 28;
	localparam logic [7:0] CRC_POLY = 8'h2f;
	localparam logic [3:0] CRC_SEED_HI = 4'h0;
	localparam logic [DATA_W-1:0] DATA_ERR_CODE = 10'h200;
	// command lengths
	localparam logic [5:0] LEN_BCAST = 6'h01;
	localparam logic [5:0] LEN_FRAG2 = 6'h02;
	localparam logic [5:0] LEN_FRAG4 = 6'h04;
	localparam logic [5:0] DIAG_BITS = 6'h20;
	localparam logic [3:0] READS_FRAG4 = 4'h4;
	localparam logic [3:0] READS_FRAG2 = 4'h8;
	// status codes
	localparam logic [3:0] STS_NORMAL   = 4'h0;
	localparam logic [3:0] STS_UNLOCKED = 4'h1;
	localparam logic [3:0] STS_SELFTEST = 4'h2;
	localparam logic [3:0] STS_OSC      = 4'h3;
	localparam logic [3:0] STS_OFFSET   = 4'h4;
	localparam logic [3:0] STS_TEMP     = 4'h5;
	localparam logic [3:0] STS_USER_NV  = 4'h8;
	localparam logic [3:0] STS_USER_RW  = 4'h9;
	localparam logic [3:0] STS_FACT_NV  = 4'ha;
	localparam logic [3:0] STS_TEST     = 4'hb;
	localparam logic [3:0] STS_SUPPLY   = 4'hc;
	localparam logic [3:0] STS_RESET    = 4'hd;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SRC0 = 8'h10;
	localparam logic [7:0] OFF_STAT = 8'h20;
	// control fields
	localparam int unsigned CTL_INIT   = 0;
	localparam int unsigned CTL_DIAG   = 1;
	localparam int unsigned CTL_FRAG4  = 2;
	localparam int unsigned CTL_SUPDIS = 3;
	localparam int unsigned CTL_SEL    = 4;
	// per-source fields and layout bits
	localparam int unsigned SRC_ID   = 0;
	localparam int unsigned SRC_LAY  = 4;
	localparam int unsigned SRC_KIND = 8;
	localparam int unsigned LAY_ID   = 2;
	localparam int unsigned LAY_KAC  = 1;
	localparam int unsigned LAY_STS  = 0;
	localparam logic [2:0] LAY_RST = 3'h7;

	typedef struct packed {
		logic [5:0]  len;
		logic [31:0] bits;
	} prf_cmd_t;

	typedef struct packed {
		logic reset_occurred_flag;
		logic supply;
		logic test_active_flag;
		logic factory_nv;
		logic user_rw;
		logic user_nv;
		logic temp;
		logic offset;
		logic osc;
		logic selftest;
		logic unlocked;
	} prf_cond_t;

	typedef struct packed {
		logic [4:0]       len;
		logic [FRM_W-1:0] bits;
	} prf_resp_t;

	typedef logic [NSRC-1:0][DATA_W-1:0] prf_samples_t;
endpackage

// File: design/prf_status_pick.sv
// Purpose: pick the status code of highest urgency
// Assumes: condition flags are levels
// Notes:   purely combinational
module prf_status_pick (
	input  prf_pkg::prf_cond_t cond,
	output logic [3:0]         code
);
	import prf_pkg::*;

	// smallest priority number wins, reserved codes never appear
	always_comb begin
		if (cond.reset_occurred_flag)   code = STS_RESET;
		else if (cond.supply)           code = STS_SUPPLY;
		else if (cond.test_active_flag) code = STS_TEST;
		else if (cond.factory_nv)       code = STS_FACT_NV;
		else if (cond.user_rw)          code = STS_USER_RW;
		else if (cond.user_nv)          code = STS_USER_NV;
		else if (cond.temp)             code = STS_TEMP;
		else if (cond.offset)           code = STS_OFFSET;
		else if (cond.osc)              code = STS_OSC;
		else if (cond.selftest)         code = STS_SELFTEST;
		else if (cond.unlocked)         code = STS_UNLOCKED;
		else                            code = STS_NORMAL;
	end
endmodule

// File: tb/dsi3_periodic_response_framer_tb_top.sv
// Purpose: self-checking bench of the periodic response framer
// Assumes: zero wait state register slave, commands two cycles apart
// Notes:   expected frames and crc are rebuilt here bit by bit
module dsi3_periodic_response_framer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import prf_pkg::*;

	logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic         cmd_valid, tmr, ok, resp_valid, diag_start;
	logic         diag_slot, diag_abort;
	logic [7:0]   haddr;
	logic [2:0]   hsize;
	logic [1:0]   htrans;
	logic [31:0]  hwdata, hrdata, diag_word;
	prf_cmd_t     cmd;
	prf_cond_t    flg;
	prf_samples_t smp;
	prf_resp_t    resp;
	int           err_count, checks_done, n_st, n_sl, n_ab, cur;
	logic [3:0]   sid [4];
	logic [2:0]   lay [4];
	logic [1:0]   kind [4];
	logic [1:0]   keep_alive_count [4];
	logic [3:0]   ex_s;
	logic [9:0]   ex_d;

	// clock and single slave ready
	always #20 hclk = ~hclk;
	assign hready = hreadyout;

	// pulse tally, mid-cycle so one pulse counts once
	always @(negedge hclk) begin
		if (diag_start === 1'b1) n_st++;
		if (diag_slot === 1'b1) n_sl++;
		if (diag_abort === 1'b1) n_ab++;
	end

	prf_framer i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .cmd_valid(cmd_valid), .cmd(cmd),
		.device_condition_flags(flg), .supply_timer_running(tmr),
		.samples(smp), .diag_cmd_ok(ok), .resp_valid(resp_valid),
		.resp(resp), .diag_word(diag_word), .diag_start(diag_start),
		.diag_read_slot(diag_slot), .diag_abort(diag_abort)
	);

	prf_master_model i_mst (.hclk(hclk), .cmd(cmd), .cmd_valid(cmd_valid));

	task print_verdict;
		if (err_count == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [63:0] seen, input logic [63:0] e);
		checks_done++;
		if (seen !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, seen);
		end
	endtask

	// one bus phase, bounded wait for ready
	task waitr;
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			err_count++;
			print_verdict();
		end
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		waitr();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		waitr();
		q = hrdata;
		chk("hresp", hresp, 1'b0);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		ahb(1'b1, a, d, q);
	endtask

	task rd(input logic [7:0] a, output logic [31:0] q);
		ahb(1'b0, a, 32'h0, q);
	endtask

	// frame as it should leave: fields, then serial crc with zeros
	function automatic prf_resp_t frm(logic [3:0] id, logic [1:0] k,
		logic [3:0] s, logic [9:0] d, logic [2:0] l);
		logic [19:0] m;
		logic [4:0]  n;
		logic [7:0]  r;
		prf_resp_t   f;
		m = '0;
		n = '0;
		if (l[2]) begin
			m = {m[15:0], id};
			n += 5'd4;
		end
		if (l[1]) begin
			m = {m[17:0], k};
			n += 5'd2;
		end
		if (l[0]) begin
			m = {m[15:0], s};
			n += 5'd4;
		end
		m = {m[9:0], d};
		n += 5'd10;
		r = {4'h0, id};
		for (int i = n + 7; i >= 0; i--)
			r = {r[6:0], (i >= 8) ? m[i - 8] : 1'b0} ^ (r[7] ? 8'h2f : 8'h00);
		f.len = n + 5'd8;
		f.bits = {m, r};
		return f;
	endfunction

	// one command and its reply, if any
	task go(input logic [5:0] len, input logic [31:0] b, input logic rep);
		i_mst.send(len, b);
		#1;
		chk("resp_valid", resp_valid, rep);
		if (rep) begin
			chk("resp", resp, frm(sid[cur], keep_alive_count[cur], ex_s, ex_d,
				lay[cur]));
			keep_alive_count[cur]++;
		end
		@(posedge hclk);
	endtask

	task frags(input int w, input logic [31:0] b, input int n);
		for (int i = 0; i < n; i++)
			go(6'(w), (b >> (32 - w * (i + 1))) & ((32'h1 << w) - 1),
				1'b1);
	endtask

	task reads(input int n);
		repeat (n) go(6'h01, 32'h1, 1'b1);
	endtask

	task setf(input logic [10:0] v);
		flg <= v;
		repeat (2) @(posedge hclk);
	endtask

	task t_reset;
		logic [31:0] q;
		rd(OFF_CTRL, q);
		chk("ctrl", q, 32'h0);
		for (int i = 0; i < 4; i++) begin
			rd(OFF_SRC0 + 8'(4 * i), q);
			chk("src", q, 32'h70 | i);
		end
		rd(OFF_STAT, q);
		chk("stat", q, 32'h0004_0000);
		wr(8'h40, 32'hffff_ffff);
		rd(8'h40, q);
		chk("unmapped", q, 32'h0);
	endtask

	task t_init;
		go(6'h01, 32'h1, 1'b0);
		wr(OFF_CTRL, 32'h1);
		@(posedge hclk);
		go(6'h02, 32'h1, 1'b0);
		go(6'h01, 32'h0, 1'b1);
		go(6'h01, 32'h1, 1'b1);
	endtask

	task t_frame;
		logic [1:0] k;
		wr(OFF_SRC0, 32'h71);
		sid[0] = 4'h1;
		repeat (5) begin
			k = keep_alive_count[0];
			go(6'h01, 32'h1, 1'b1);
			if (k == 2'h3) chk("crc", resp.bits[7:0], 8'hd6);
		end
		wr(OFF_SRC0 + 8'h04, 32'h273);
		wr(OFF_CTRL, 32'h11);
		cur = 1;
		sid[1] = 4'h3;
		kind[1] = 2'h2;
		ex_d = smp[kind[1]];
		go(6'h01, 32'h0, 1'b1);
		go(6'h01, 32'h0, 1'b1);
		chk("crc", resp.bits[7:0], 8'hb0);
	endtask

	task t_prio;
		logic [3:0] cd [11];
		cd = '{STS_UNLOCKED, STS_SELFTEST, STS_OSC, STS_OFFSET, STS_TEMP,
			STS_USER_NV, STS_USER_RW, STS_FACT_NV, STS_TEST, STS_SUPPLY,
			STS_RESET};
		for (int i = 0; i < 11; i++) begin
			if (i == 9) continue;
			setf(11'((1 << (i + 1)) - 1) & 11'h5ff);
			ex_s = cd[i];
			ex_d = cd[i][3] ? DATA_ERR_CODE : smp[2];
			go(6'h01, 32'h1, 1'b1);
		end
		wr(OFF_SRC0 + 8'h04, 32'h263);
		lay[1] = 3'h6;
		setf(11'h001);
		ex_d = DATA_ERR_CODE;
		go(6'h01, 32'h1, 1'b1);
		setf(11'h000);
		ex_s = STS_NORMAL;
		ex_d = smp[2];
		go(6'h01, 32'h1, 1'b1);
		wr(OFF_SRC0 + 8'h04, 32'h213);
		lay[1] = 3'h1;
		go(6'h01, 32'h1, 1'b1);
		wr(OFF_SRC0 + 8'h04, 32'h273);
		lay[1] = 3'h7;
	endtask

	task t_supply;
		tmr <= 1'b1;
		setf(11'h200);
		go(6'h01, 32'h1, 1'b0);
		tmr <= 1'b0;
		@(posedge hclk);
		ex_s = STS_SUPPLY;
		ex_d = DATA_ERR_CODE;
		go(6'h01, 32'h1, 1'b1);
		wr(OFF_CTRL, 32'h19);
		ex_d = smp[2];
		go(6'h01, 32'h1, 1'b1);
		setf(11'h000);
		ex_s = STS_NORMAL;
	endtask

	task t_diag;
		logic [31:0] q;
		wr(OFF_CTRL, 32'h17);
		go(6'h02, 32'h1, 1'b0);
		frags(4, 32'h1234_abcd, 8);
		@(posedge hclk);
		chk("diag_word", diag_word, 32'h1234_abcd);
		chk("start", n_st, 1);
		reads(5);
		chk("slots", n_sl, 4);
		frags(4, 32'h5, 3);
		rd(OFF_STAT, q);
		chk("count", q[17:12], 6'd12);
		go(6'h03, 32'h5, 1'b0);
		rd(OFF_STAT, q);
		chk("count", q[17:12], 6'd0);
		frags(4, 32'h5, 3);
		go(6'h01, 32'h0, 1'b1);
		rd(OFF_STAT, q);
		chk("count", q[17:12], 6'd0);
		ok <= 1'b0;
		frags(4, 32'h9abc_def0, 8);
		@(posedge hclk);
		chk("start", n_st, 1);
		ok <= 1'b1;
		go(6'h01, 32'h0, 1'b1);
		frags(4, 32'h9abc_def0, 8);
		@(posedge hclk);
		go(6'h01, 32'h0, 1'b1);
		go(6'h04, 32'h3, 1'b1);
		chk("abort", n_ab, 1);
		wr(OFF_CTRL, 32'h13);
		go(6'h01, 32'h0, 1'b1);
		frags(2, 32'h0f0f_5a5a, 16);
		@(posedge hclk);
		chk("diag_word", diag_word, 32'h0f0f_5a5a);
		reads(9);
		chk("slots", n_sl, 13);
		chk("start", n_st, 3);
	endtask

	// main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		hwdata = 32'h0;
		flg = '0;
		tmr = 1'b0;
		ok = 1'b1;
		smp = {10'h155, 10'h20d, 10'h0c3, 10'h1ff};
		err_count = 0;
		checks_done = 0;
		n_st = 0;
		n_sl = 0;
		n_ab = 0;
		cur = 0;
		ex_s = STS_NORMAL;
		ex_d = 10'h1ff;
		for (int i = 0; i < 4; i++) begin
			sid[i] = 4'(i);
			lay[i] = 3'h7;
			kind[i] = 2'h0;
			keep_alive_count[i] = 2'h0;
		end
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_init();
		t_frame();
		t_prio();
		t_supply();
		t_diag();
		print_verdict();
	end
endmodule

// File: tb/prf_master_model.sv
// Purpose: command side of the bus master facing the framer
// Assumes: send is called right after a rising edge of hclk
// Notes:   lines are scrambled once a command has been taken
module prf_master_model (
	input  wire logic         hclk,
	output prf_pkg::prf_cmd_t cmd,
	output logic              cmd_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	import prf_pkg::*;

	// idle lines at time zero
	initial begin
		cmd_valid = 1'b0;
		cmd = '0;
	end

	// one command: a read of either value or a right aligned fragment
	task send(input logic [5:0] len, input logic [31:0] b);
		cmd_valid <= 1'b1;
		cmd <= '{len: len, bits: b};
		@(posedge hclk);
		cmd_valid <= 1'b0;
		cmd <= '{len: ~len, bits: ~b}; // stale values must not look valid
	endtask
endmodule
